// [hdl/host_port_pkg.sv]
// Register map, reset values and bus state codes of the host bus, interrupt and port logic
package host_port_pkg;
    // Register select codes, four lines
    localparam logic [3:0] REG_MODE_FIRST = 4'h0;
    localparam logic [3:0] REG_STATUS_FIRST = 4'h1;
    localparam logic [3:0] REG_CMD_FIRST = 4'h2;
    localparam logic [3:0] REG_AUX_CHANGE = 4'h4;
    localparam logic [3:0] REG_MASK_PENDING = 4'h5;
    localparam logic [3:0] REG_INPUT_ALT = 4'h6;
    localparam logic [3:0] REG_MODE_SECOND = 4'h8;
    localparam logic [3:0] REG_STATUS_SECOND = 4'h9;
    localparam logic [3:0] REG_CMD_SECOND = 4'hA;
    localparam logic [3:0] REG_VECTOR = 4'hC;
    localparam logic [3:0] REG_OUTCFG_INPORT = 4'hD;
    localparam logic [3:0] REG_LATCH_SET = 4'hE;
    localparam logic [3:0] REG_LATCH_CLEAR = 4'hF;
    // Values after reset
    localparam logic [7:0] VECTOR_RESET = 8'h0F;
    localparam logic [7:0] AUX_CONTROL_RESET = 8'h40;
    localparam int AUX_TIMER_MODE_BIT = 6;
    localparam int MODE_RTS_BIT = 7;
    // Change detector sampling divisor of the reference clock
    localparam int SAMPLE_DIV = 96;
    // Channel command field, data bits 6:4
    localparam logic [2:0] CMD_RESET_RX = 3'h2;
    localparam logic [2:0] CMD_RESET_TX = 3'h3;
    localparam logic [2:0] CMD_RESET_ERR = 3'h4;
    localparam logic [2:0] CMD_RESET_BRK = 3'h5;
    localparam int CMD_RX_ON_BIT = 0;
    localparam int CMD_RX_OFF_BIT = 1;
    localparam int CMD_TX_ON_BIT = 2;
    localparam int CMD_TX_OFF_BIT = 3;
    // Bus cycle sequencer
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ACT = 3'b001,
        BUS_ACK = 3'b010,
        BUS_RELEASE = 3'b011,
        BUS_IGNORE = 3'b100
    } bus_state_e;
endpackage

// [hdl/host_bus_irq_port_logic.sv]
// Host parallel bus, interrupt, input port change detection and output latch logic
//
// Behaviour
// - Interrupt output asserts only for events enabled in the interrupt enable mask.
// - Pending event status read shows every active condition, mask ignored.
// - Vector request with interrupt pending drives vector, then asserts acknowledge.
// - Vector request with nothing pending is ignored, no acknowledge.
// - Transmitter, receiver and timer interrupts may be routed to upper output pins.
// - Input port read gives one for high pins, zero for low pins.
// - Each input pin independently switches between plain input and alternate use.
// - First four inputs sampled at clock/96; two equal new samples set change bit.
// - Change of state may raise an interrupt under program control.
// - Reading the input change register clears its four change bits; the input state bits stay.
// - Write to set address sets latch bits written as one.
// - Write to clear address clears latch bits written as one.
// - Output pins show the inverse of the output latch bits.
// - Output pins can take auxiliary channel functions via mode and configuration.
// - Reset clears channel status, mask, pending status, latch and output configuration.
// - Reset loads the vector register with 0F hex.
// - Reset drives all output pins high and selects timer mode.
// - Reset makes both channels inactive with serial outputs at mark.
// - Channel commands reset receiver, transmitter, error status or break interrupt.
// - Register transfers only while select low, vector reads while vector request low; data lines released while both are high.
// - Host starts a cycle with select, direction high for read, low for write.
// - Acknowledge asserted in read, write and vector cycles, driven high, then released.
// - Register select lines with select and direction choose the register or command.
// - Acknowledge means write data latched or read or vector data valid.
`timescale 1ns/10ps
module host_bus_irq_port_logic
    import host_port_pkg::*;
#(
    parameter int SAMPLE_DIVISOR = SAMPLE_DIV
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic chip_select_n_in,
    input wire logic read_write_in,
    input wire logic vector_request_n_in,
    input wire logic [3:0] register_select_lines_in,
    input wire logic [7:0] data_lines_in,
    input wire logic [5:0] input_pins_in,
    input wire logic [6:0] event_sources_in,
    input wire logic [7:0] status_first_in,
    input wire logic [7:0] status_second_in,
    input wire logic [7:0] aux_function_in,
    input wire logic tx_serial_first_in,
    input wire logic tx_serial_second_in,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe_out,
    output logic transfer_ack_n_out,
    output logic transfer_ack_oe_out,
    output logic interrupt_n_out,
    output logic [7:0] output_pins_out,
    output logic serial_out_first_out,
    output logic serial_out_second_out,
    output logic [5:0] alt_inputs_out,
    output logic timer_mode_out,
    output logic [1:0] rx_active_out,
    output logic [1:0] rx_reset_out,
    output logic [1:0] tx_reset_out,
    output logic [1:0] err_reset_out,
    output logic [1:0] brk_reset_out
);

    // Divider below two leaves no room for two distinct samples
    if (SAMPLE_DIVISOR < 2 || SAMPLE_DIVISOR > 127)
    begin : g_bad_div
        $error("SAMPLE_DIVISOR out of range 2..127");
    end

    localparam logic [6:0] DIV_LAST = 7'(SAMPLE_DIVISOR - 1);

    typedef struct packed {
        logic [1:0] cs_n;
        logic [1:0] rw;
        logic [1:0] vector_request_n_n;
        logic [7:0] addr;
        logic [15:0] data;
        logic [11:0] pins;
        bus_state_e state;
        logic [3:0] cyc_addr;
        logic cyc_read;
        logic [7:0] rd_data;
        logic data_oe;
        logic ack_n;
        logic ack_oe;
        logic [7:0] interrupt_enable_mask;
        logic [7:0] pending_event_status;
        logic [7:0] vector_register;
        logic [7:0] auxiliary_control_register;
        logic [7:0] output_configuration_register;
        logic [7:0] latch;
        logic [7:0] mode_first;
        logic [7:0] mode_second;
        logic [7:0] status_first;
        logic [7:0] status_second;
        logic [5:0] ip_alt_en;
        logic [6:0] div_cnt;
        logic [3:0] samp_prev;
        logic [3:0] stable;
        logic primed;
        logic [3:0] chg;
        logic int_n;
        logic [7:0] out_pins;
        logic ser_first;
        logic ser_second;
        logic [1:0] tx_active;
        logic [1:0] rx_active;
        logic [1:0] rx_rst;
        logic [1:0] tx_rst;
        logic [1:0] err_rst;
        logic [1:0] brk_rst;
        logic [5:0] alt_in;
    } state_s;

    state_s st;
    state_s next_st;

    // Channel command decode: {brk, err, tx, rx} reset pulses
    function automatic logic [3:0] cmd_pulses(input logic [7:0] d);
        cmd_pulses = {d[6:4] == CMD_RESET_BRK, d[6:4] == CMD_RESET_ERR,
            d[6:4] == CMD_RESET_TX, d[6:4] == CMD_RESET_RX};
    endfunction

    // Helper views of the synchronised pins and of the state
    logic cs_low;
    logic rw_high;
    logic vector_request_n_low;
    logic [3:0] addr_s;
    logic [7:0] data_s;
    logic [5:0] pins_s;
    logic pending;
    logic tick;
    logic [7:0] alt_sel;
    logic [3:0] cmd_a;

    assign cs_low = !st.cs_n[1];
    assign rw_high = st.rw[1];
    assign vector_request_n_low = !st.vector_request_n_n[1];
    assign addr_s = st.addr[7:4];
    assign data_s = st.data[15:8];
    assign pins_s = st.pins[11:6];
    assign pending = !st.int_n;
    assign tick = st.div_cnt == DIV_LAST;
    assign cmd_a = cmd_pulses(data_s);

    // Whole next state; the bus cycle runs first so hardware sets override clears
    always_comb
    begin
        next_st = st;
        next_st.cs_n = {st.cs_n[0], chip_select_n_in};
        next_st.rw = {st.rw[0], read_write_in};
        next_st.vector_request_n_n = {st.vector_request_n_n[0], vector_request_n_in};
        next_st.addr = {st.addr[3:0], register_select_lines_in};
        next_st.data = {st.data[7:0], data_lines_in};
        next_st.pins = {st.pins[5:0], input_pins_in};
        next_st.status_first = status_first_in;
        next_st.status_second = status_second_in;
        next_st.rx_rst = 2'h0;
        next_st.tx_rst = 2'h0;
        next_st.err_rst = 2'h0;
        next_st.brk_rst = 2'h0;
        next_st.div_cnt = tick ? 7'h00 : st.div_cnt + 7'h01;
        case (st.state)
            BUS_IDLE:
            begin
                next_st.cyc_addr = addr_s;
                next_st.cyc_read = rw_high;
                if (cs_low)
                begin
                    next_st.state = BUS_ACT;
                end
                else if (vector_request_n_low && pending)
                begin
                    next_st.rd_data = st.vector_register;
                    next_st.data_oe = 1'b1;
                    next_st.state = BUS_ACT;
                end
                else if (vector_request_n_low)
                begin
                    next_st.state = BUS_IGNORE;
                end
            end
            BUS_ACT:
            begin
                next_st.state = BUS_ACK;
                next_st.ack_n = 1'b0;
                next_st.ack_oe = 1'b1;
                if (!cs_low)
                begin
                    // Vector cycle, data already on the lines
                    next_st.data_oe = 1'b1;
                end
                else if (st.cyc_read)
                begin
                    next_st.data_oe = 1'b1;
                    case (st.cyc_addr)
                        REG_MODE_FIRST: next_st.rd_data = st.mode_first;
                        REG_STATUS_FIRST: next_st.rd_data = st.status_first;
                        REG_AUX_CHANGE:
                        begin
                            next_st.rd_data = {st.chg, st.stable};
                            next_st.chg = 4'h0;
                        end
                        REG_MASK_PENDING: next_st.rd_data = st.pending_event_status;
                        REG_MODE_SECOND: next_st.rd_data = st.mode_second;
                        REG_STATUS_SECOND: next_st.rd_data = st.status_second;
                        REG_VECTOR: next_st.rd_data = st.vector_register;
                        REG_OUTCFG_INPORT: next_st.rd_data = {2'h0, pins_s};
                        default: next_st.rd_data = 8'h00;
                    endcase
                end
                else
                begin
                    case (st.cyc_addr)
                        REG_MODE_FIRST: next_st.mode_first = data_s;
                        REG_MODE_SECOND: next_st.mode_second = data_s;
                        REG_CMD_FIRST:
                        begin
                            {next_st.brk_rst[0], next_st.err_rst[0], next_st.tx_rst[0], next_st.rx_rst[0]} = cmd_a;
                            if (data_s[CMD_RX_ON_BIT]) next_st.rx_active[0] = 1'b1;
                            if (data_s[CMD_RX_OFF_BIT] || cmd_a[0]) next_st.rx_active[0] = 1'b0;
                            if (data_s[CMD_TX_ON_BIT]) next_st.tx_active[0] = 1'b1;
                            if (data_s[CMD_TX_OFF_BIT] || cmd_a[1]) next_st.tx_active[0] = 1'b0;
                        end
                        REG_CMD_SECOND:
                        begin
                            {next_st.brk_rst[1], next_st.err_rst[1], next_st.tx_rst[1], next_st.rx_rst[1]} = cmd_a;
                            if (data_s[CMD_RX_ON_BIT]) next_st.rx_active[1] = 1'b1;
                            if (data_s[CMD_RX_OFF_BIT] || cmd_a[0]) next_st.rx_active[1] = 1'b0;
                            if (data_s[CMD_TX_ON_BIT]) next_st.tx_active[1] = 1'b1;
                            if (data_s[CMD_TX_OFF_BIT] || cmd_a[1]) next_st.tx_active[1] = 1'b0;
                        end
                        REG_AUX_CHANGE: next_st.auxiliary_control_register = data_s;
                        REG_MASK_PENDING: next_st.interrupt_enable_mask = data_s;
                        REG_INPUT_ALT: next_st.ip_alt_en = data_s[5:0];
                        REG_VECTOR: next_st.vector_register = data_s;
                        REG_OUTCFG_INPORT: next_st.output_configuration_register = data_s;
                        REG_LATCH_SET: next_st.latch = st.latch | data_s;
                        REG_LATCH_CLEAR: next_st.latch = st.latch & ~data_s;
                        default: next_st.latch = st.latch;
                    endcase
                end
            end
            BUS_ACK:
            begin
                // Data released and acknowledge driven high once select and vector request are both seen high
                if (!cs_low && !vector_request_n_low)
                begin
                    next_st.data_oe = 1'b0;
                    next_st.ack_n = 1'b1;
                    next_st.state = BUS_RELEASE;
                end
            end
            BUS_RELEASE:
            begin
                next_st.ack_oe = 1'b0;
                next_st.state = BUS_IDLE;
            end
            BUS_IGNORE: if (!vector_request_n_low) next_st.state = BUS_IDLE;
            default: next_st.state = BUS_IDLE;
        endcase
        // Change detectors; a set in the clearing cycle wins
        if (tick)
        begin
            next_st.samp_prev = pins_s[3:0];
            next_st.primed = 1'b1;
            if (!st.primed)
            begin
                next_st.stable = pins_s[3:0];
            end
            for (int i = 0; i < 4; i++)
            begin
                if (st.primed && pins_s[i] == st.samp_prev[i] && pins_s[i] != st.stable[i])
                begin
                    next_st.stable[i] = pins_s[i];
                    next_st.chg[i] = 1'b1;
                end
            end
        end
        next_st.pending_event_status = {|(next_st.chg & next_st.auxiliary_control_register[3:0]), event_sources_in};
        next_st.int_n = !(|(next_st.pending_event_status & next_st.interrupt_enable_mask));
        // Pin functions: auxiliary source or inverted latch
        alt_sel = {next_st.output_configuration_register[7:4], |next_st.output_configuration_register[3:2], |next_st.output_configuration_register[1:0],
            next_st.mode_second[MODE_RTS_BIT], next_st.mode_first[MODE_RTS_BIT]};
        next_st.out_pins = (alt_sel & aux_function_in) | (~alt_sel & ~next_st.latch);
        next_st.ser_first = next_st.tx_active[0] ? tx_serial_first_in : 1'b1;
        next_st.ser_second = next_st.tx_active[1] ? tx_serial_second_in : 1'b1;
        next_st.alt_in = pins_s & next_st.ip_alt_en;
    end

    // State register; reset values are constants only
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st <= '0;
            st.cs_n <= 2'h3;
            st.rw <= 2'h3;
            st.vector_request_n_n <= 2'h3;
            st.state <= BUS_IDLE;
            st.ack_n <= 1'b1;
            st.vector_register <= VECTOR_RESET;
            st.auxiliary_control_register <= AUX_CONTROL_RESET;
            st.int_n <= 1'b1;
            st.out_pins <= 8'hFF;
            st.ser_first <= 1'b1;
            st.ser_second <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign data_lines_out = st.rd_data;
    assign data_lines_oe_out = st.data_oe;
    assign transfer_ack_n_out = st.ack_n;
    assign transfer_ack_oe_out = st.ack_oe;
    assign interrupt_n_out = st.int_n;
    assign output_pins_out = st.out_pins;
    assign serial_out_first_out = st.ser_first;
    assign serial_out_second_out = st.ser_second;
    assign alt_inputs_out = st.alt_in;
    assign timer_mode_out = st.auxiliary_control_register[AUX_TIMER_MODE_BIT];
    assign rx_active_out = st.rx_active;
    assign rx_reset_out = st.rx_rst;
    assign tx_reset_out = st.tx_rst;
    assign err_reset_out = st.err_rst;
    assign brk_reset_out = st.brk_rst;

    // Checks on the logic above
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence vec_start;
        st.state == BUS_IDLE && !cs_low && vector_request_n_low && pending;
    endsequence
    sequence vec_answer;
        data_lines_oe_out && data_lines_out == st.vector_register ##1 !transfer_ack_n_out && transfer_ack_oe_out;
    endsequence

    AST_INT_LEVEL: assert property (interrupt_n_out ==
        !(|({|(st.chg & st.auxiliary_control_register[3:0]), $past(event_sources_in)} & st.interrupt_enable_mask)))
        else $error("interrupt level does not follow enabled events");
    AST_VEC_ACK: assert property (vec_start |=> vec_answer)
        else $error("vector cycle answered wrongly");
    AST_NO_ACK: assert property (st.state == BUS_IDLE && !cs_low && vector_request_n_low && !pending
        |=> (!transfer_ack_oe_out && !data_lines_oe_out) [*2])
        else $error("unpending vector cycle answered");
    AST_SET: assert property (st.state == BUS_ACT && cs_low && !st.cyc_read && st.cyc_addr == REG_LATCH_SET
        |=> st.latch == ($past(st.latch) | $past(data_s)))
        else $error("latch set wrong");
    AST_CLR: assert property (st.state == BUS_ACT && cs_low && !st.cyc_read && st.cyc_addr == REG_LATCH_CLEAR
        |=> st.latch == ($past(st.latch) & ~$past(data_s)))
        else $error("latch clear wrong");
    AST_PIN_INV: assert property (!st.output_configuration_register[7] |-> output_pins_out[7] == !st.latch[7])
        else $error("output pin not inverse of latch");
    AST_CHG_CLR: assert property (st.state == BUS_ACT && cs_low && st.cyc_read && st.cyc_addr == REG_AUX_CHANGE
        && !tick |=> st.chg == 4'h0)
        else $error("change register not cleared by read");
    AST_OE_CS: assert property (data_lines_oe_out |-> !$past(st.cs_n[1]) || !$past(st.vector_request_n_n[1]))
        else $error("data driven without select");
    AST_ACK_REL: assert property ($rose(transfer_ack_n_out) && transfer_ack_oe_out |=> !transfer_ack_oe_out)
        else $error("acknowledge not released");

endmodule // host_bus_irq_port_logic

// [test/host_cpu_model.sv]
// Host processor model driving select, direction and vector request cycles
`timescale 1ns/10ps
module host_cpu_model
(
    input wire logic clk_in,
    input wire logic [7:0] bus_data_in,
    input wire logic ack_bus_n_in,
    output logic chip_select_n_out,
    output logic read_write_out,
    output logic vector_request_n_out,
    output logic [3:0] addr_out,
    output logic [7:0] data_out
);
    // Idle levels from time zero
    initial
    begin
        chip_select_n_out = 1'b1;
        read_write_out = 1'b1;
        vector_request_n_out = 1'b1;
        addr_out = 4'h0;
        data_out = 8'h00;
    end

    // Request held until ack is low at a rising edge or 12 edges pass, data taken at the last edge
    task automatic run(input logic vec, input logic rd, input logic [3:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat, output logic acked);
        int n;
        begin
            @(negedge clk_in);
            read_write_out = rd;
            addr_out = a;
            data_out = wd;
            if (vec)
                vector_request_n_out = 1'b0;
            else
                chip_select_n_out = 1'b0;
            acked = 1'b0;
            rdat = 8'h00;
            for (n = 0; n < 12 && !acked; n++)
            begin
                @(posedge clk_in);
                acked = (ack_bus_n_in === 1'b0);
                rdat = bus_data_in;
            end
            @(negedge clk_in);
            chip_select_n_out = 1'b1;
            vector_request_n_out = 1'b1;
            data_out = ~wd; // Released lines must not keep the last value
            addr_out = ~a;
            repeat (8) @(posedge clk_in);
        end
    endtask
endmodule // host_cpu_model

// [test/tb_top.sv]
// Self-checking bench of the host bus, interrupt and port logic
`timescale 1ns/10ps
module tb_top;
    import host_port_pkg::*;
    typedef struct {logic rd; logic [3:0] a; logic [7:0] d; logic [7:0] exp_rd; logic [7:0] exp_pins;} row_s;
    logic ref_clk_in, reset_in, cs_n, rw, vreq_n, s1, s2, data_oe, ack_n, ack_oe, int_n, timer_mode;
    logic [3:0] addr;
    logic [7:0] host_dq, dev_dq, pins, aux_fn, pulse_seen, got;
    logic [5:0] in_pins, alt_in;
    logic [6:0] events;
    logic [1:0] rx_act, rx_rst, tx_rst, err_rst, brk_rst;
    logic ok, seen_clr;
    wire logic [7:0] data_bus = data_oe ? dev_dq : host_dq;
    wire logic ack_bus = ack_oe ? ack_n : 1'b1; // Pull-up while released
    int miscompares = 0;
    int check_count = 0;
    row_s rows[10] = '{
        '{1'b0, 4'hE, 8'h05, 8'h00, 8'hFA},
        '{1'b0, 4'hE, 8'h80, 8'h00, 8'h7A},
        '{1'b0, 4'hF, 8'h04, 8'h00, 8'h7E},
        '{1'b0, 4'hF, 8'h00, 8'h00, 8'h7E},
        '{1'b1, 4'hD, 8'h00, 8'h2A, 8'h7E},
        '{1'b1, 4'h9, 8'h00, 8'h5C, 8'h7E},
        '{1'b0, 4'hC, 8'hA5, 8'h00, 8'h7E},
        '{1'b1, 4'hC, 8'h00, 8'hA5, 8'h7E},
        '{1'b1, 4'h3, 8'h00, 8'h00, 8'h7E},
        '{1'b1, 4'h4, 8'h00, 8'h0A, 8'h7E}
    };

    host_bus_irq_port_logic #(.SAMPLE_DIVISOR(4)) uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .chip_select_n_in(cs_n), .read_write_in(rw), .vector_request_n_in(vreq_n),
        .register_select_lines_in(addr), .data_lines_in(data_bus), .input_pins_in(in_pins),
        .event_sources_in(events), .status_first_in(8'h00), .status_second_in(8'h5C),
        .aux_function_in(aux_fn), .tx_serial_first_in(1'b0), .tx_serial_second_in(1'b0),
        .data_lines_out(dev_dq), .data_lines_oe_out(data_oe), .transfer_ack_n_out(ack_n),
        .transfer_ack_oe_out(ack_oe), .interrupt_n_out(int_n), .output_pins_out(pins),
        .serial_out_first_out(s1), .serial_out_second_out(s2), .alt_inputs_out(alt_in),
        .timer_mode_out(timer_mode), .rx_active_out(rx_act), .rx_reset_out(rx_rst),
        .tx_reset_out(tx_rst), .err_reset_out(err_rst), .brk_reset_out(brk_rst));

    host_cpu_model host (.clk_in(ref_clk_in), .bus_data_in(data_bus), .ack_bus_n_in(ack_bus),
        .chip_select_n_out(cs_n), .read_write_out(rw), .vector_request_n_out(vreq_n),
        .addr_out(addr), .data_out(host_dq));

    // Clock, 25 ns period
    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    // Sticky capture, since command pulses last one cycle only
    always @(posedge ref_clk_in)
        pulse_seen <= seen_clr ? 8'h00 : pulse_seen | {rx_rst, tx_rst, err_rst, brk_rst};

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.run(1'b0, 1'b0, a, d, got, ok);
        check("write ack", {7'h00, ok}, 8'h01);
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        host.run(1'b0, 1'b1, a, 8'h00, got, ok);
        check("read ack", {7'h00, ok}, 8'h01);
        check(nm, got, exp);
    endtask

    task automatic reset_check();
        check("pins after reset", pins, 8'hFF);
        check("serial outs", {6'h00, s1, s2}, 8'h03);
        check("timer mode", {7'h00, timer_mode}, 8'h01);
        check("rx active", {6'h00, rx_act}, 8'h00);
        check("irq idle", {7'h00, int_n}, 8'h01);
        rd_chk("vector reset", REG_VECTOR, VECTOR_RESET);
        rd_chk("pending reset", REG_MASK_PENDING, 8'h00);
    endtask

    // Cuts a hang short
    initial
    begin
        #(25ns * 20000);
        miscompares++;
        test_done();
    end

    initial
    begin
        reset_in = 1'b1;
        in_pins = 6'h2A;
        events = 7'h00;
        aux_fn = 8'h00;
        seen_clr = 1'b1;
        repeat (16) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        reset_in = 1'b0;
        seen_clr = 1'b0;
        reset_check();
        // Table of ordinary register cycles
        foreach (rows[i])
        begin
            host.run(1'b0, rows[i].rd, rows[i].a, rows[i].d, got, ok);
            check("row ack", {7'h00, ok}, 8'h01);
            if (rows[i].rd)
                check("row data", got, rows[i].exp_rd);
            check("row pins", pins, rows[i].exp_pins);
            check("data released", {6'h00, data_oe, ack_oe}, 8'h00);
        end
        // Masked event, vector cycle ignored then answered
        @(negedge ref_clk_in);
        events = 7'h01;
        repeat (3) @(posedge ref_clk_in);
        check("masked irq", {7'h00, int_n}, 8'h01);
        rd_chk("pending unmasked view", REG_MASK_PENDING, 8'h01);
        host.run(1'b1, 1'b1, 4'h0, 8'h00, got, ok);
        check("vector ignored", {7'h00, ok}, 8'h00);
        wr(REG_MASK_PENDING, 8'h01);
        check("enabled irq", {7'h00, int_n}, 8'h00);
        host.run(1'b1, 1'b1, 4'h0, 8'h00, got, ok);
        check("vector ack", {7'h00, ok}, 8'h01);
        check("vector data", got, 8'hA5);
        @(negedge ref_clk_in);
        events = 7'h00;
        repeat (3) @(posedge ref_clk_in);
        check("irq level drop", {7'h00, int_n}, 8'h01);
        // Change of state on input 0 with its interrupt enabled
        wr(REG_AUX_CHANGE, 8'h01);
        check("counter mode", {7'h00, timer_mode}, 8'h00);
        wr(REG_MASK_PENDING, 8'h80);
        @(negedge ref_clk_in);
        in_pins = 6'h2B;
        repeat (30) @(posedge ref_clk_in);
        check("change irq", {7'h00, int_n}, 8'h00);
        rd_chk("change seen", REG_AUX_CHANGE, 8'h1B);
        rd_chk("change cleared", REG_AUX_CHANGE, 8'h0B);
        check("change irq gone", {7'h00, int_n}, 8'h01);
        // Alternate input enables and auxiliary output selection
        wr(REG_INPUT_ALT, 8'h3F);
        check("alt inputs", {2'b00, alt_in}, 8'h2B);
        wr(REG_OUTCFG_INPORT, 8'h10);
        check("aux pin 4", pins, 8'h6E);
        wr(REG_CMD_FIRST, 8'h01);
        check("rx enable", {6'h00, rx_act}, 8'h01);
        // Every reset command on both channels
        for (int c = 2; c <= 5; c++)
        begin
            for (int ch = 0; ch < 2; ch++)
            begin
                @(negedge ref_clk_in);
                seen_clr = 1'b1;
                @(negedge ref_clk_in);
                seen_clr = 1'b0;
                wr(ch ? REG_CMD_SECOND : REG_CMD_FIRST, {1'b0, c[2:0], 4'h0});
                check("command pulse", pulse_seen, 8'h01 << ((5 - c) * 2 + ch));
            end
        end
        // Both channels on, so the reset below has something to undo
        wr(REG_CMD_FIRST, 8'h05);
        wr(REG_CMD_SECOND, 8'h05);
        check("channels on", {4'h0, rx_act, s1, s2}, 8'h0C);
        // Second reset in mid-run
        @(negedge ref_clk_in);
        reset_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        reset_in = 1'b0;
        reset_check();
        test_done();
    end
endmodule // tb_top
